// ### logic/smsr_pkg.sv
package smsr_pkg;

  // ==========================================
  // status byte field positions
  localparam int unsigned POS_GUARD = 7;
  localparam int unsigned POS_QUAD = 6;
  localparam int unsigned POS_LAT_HI = 5;
  localparam int unsigned POS_LAT_LO = 4;
  localparam int unsigned POS_BP_HI = 3;
  localparam int unsigned POS_BP_LO = 2;
  localparam int unsigned POS_LATCH = 1;
  localparam int unsigned POS_ZERO = 0;
  // status register two positions
  localparam int unsigned POS2_QUAD = 6;
  localparam int unsigned POS2_DUAL = 5;

  // ==========================================
  // nonvolatile field: {guard, lat[1:0], bp[1:0]}
  localparam int unsigned NV_W = 5;
  localparam logic [4:0] NV_ERASED = 5'h00;
  localparam logic VOL_RESET = 1'b0;

  // ==========================================
  // op-codes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_RD_STAT1 = 8'h05;
  localparam logic [7:0] OP_WR_STAT1 = 8'h01;
  localparam logic [7:0] OP_RD_STAT2 = 8'h35;
  localparam logic [7:0] OP_ENTER_DUAL = 8'h37;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
  localparam logic [7:0] OP_EXIT_MULTI = 8'hFF;

  // ==========================================
  // lane counts per link edge
  localparam logic [3:0] LANES_1 = 4'h1;
  localparam logic [3:0] LANES_2 = 4'h2;
  localparam logic [3:0] LANES_4 = 4'h4;
  localparam logic [3:0] BITS_BYTE = 4'h8;

  typedef enum logic [1:0] {
    SMSR_OPCODE,
    SMSR_WRDATA,
    SMSR_RDOUT,
    SMSR_IGNORE
  } smsr_state_e;

endpackage

// ### logic/smsr_nv_cells.sv
`timescale 1ns/1ps
module smsr_nv_cells (
  // clock and factory erase
  input wire logic clk_sys,
  input wire logic nv_erase_n,
  // update port
  input wire logic wr_en,
  input wire logic [4:0] wr_data,
  // stored value
  output logic [4:0] nv_q
);

  // ==========================================
  // storage
  // deliberately not on resetn: content outlives power cycles
  always_ff @(posedge clk_sys or negedge nv_erase_n) begin
    if (!nv_erase_n) begin
      nv_q <= smsr_pkg::NV_ERASED;
    end else if (wr_en) begin
      nv_q <= wr_data;
    end
  end

endmodule

// ### logic/smsr_status1.sv
`timescale 1ns/1ps
// What this block does
// - guard enable kept nonvolatile at bit seven
// - guard plus protect pin block status writes outside quad mode
// - status write/read cover guard, latency, protect
// - quad mode flag volatile, zero at power-on
// - enter-quad sets; exit or enter-dual clears
// - status write leaves quad flag untouched
// - quad flag identical in both status registers
// - latency bits five, four kept nonvolatile
// - protect bits three, two kept nonvolatile
// - write latch bit one, zero after power-on
// - set/clear latch commands drive write latch
// - latch readable, status write value ignored
// - latch cleared at power-on and clear command
// - latch stays set after any write
// - bit zero always reads zero
module smsr_status1 (
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic nv_erase_n,
  // serial link pins
  input wire logic link_sck,
  input wire logic link_cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oen,
  // state seen by the rest of the device
  output logic quad_io_protocol_mode,
  output logic dual_io_protocol_mode,
  output logic write_enable_latch,
  output logic [1:0] latency_sel,
  output logic [1:0] block_protect,
  output logic status_write_guard_enable
);

  // ==========================================
  // pin synchronisers
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic cs_s1_r, cs_s2_r;
  logic [3:0] io_s1_r, io_s2_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      sck_s1_r <= link_sck;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      cs_s1_r <= link_cs_n;
      cs_s2_r <= cs_s1_r;
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
    end
  end

  logic sel, sck_rise, sck_fall;
  assign sel = !cs_s2_r;
  assign sck_rise = sel && sck_s2_r && !sck_s3_r;
  assign sck_fall = sel && !sck_s2_r && sck_s3_r;

  // ==========================================
  // status contents
  logic quad_r, dual_r, latch_r;
  logic [4:0] nv_q;
  logic nv_wr;
  logic [7:0] rx_nxt;
  logic [7:0] stat1, stat2;

  smsr_nv_cells u_nv (
    .clk_sys(clk_sys),
    .nv_erase_n(nv_erase_n),
    .wr_en(nv_wr),
    // guard, latency, protect fields taken from the write byte
    .wr_data({rx_nxt[smsr_pkg::POS_GUARD],
              rx_nxt[smsr_pkg::POS_LAT_HI:smsr_pkg::POS_BP_LO]}),
    .nv_q(nv_q)
  );

  always_comb begin
    stat1 = 8'h00;
    stat1[smsr_pkg::POS_GUARD] = nv_q[4];
    stat1[smsr_pkg::POS_QUAD] = quad_r;
    stat1[smsr_pkg::POS_LAT_HI:smsr_pkg::POS_BP_LO] = nv_q[3:0];
    stat1[smsr_pkg::POS_LATCH] = latch_r;
    stat2 = 8'h00;
    stat2[smsr_pkg::POS2_QUAD] = quad_r;
    stat2[smsr_pkg::POS2_DUAL] = dual_r;
  end

  // ==========================================
  // receive path
  smsr_pkg::smsr_state_e state_r;
  logic [7:0] rx_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] lanes;
  logic byte_done;

  assign lanes = quad_r ? smsr_pkg::LANES_4 :
                 (dual_r ? smsr_pkg::LANES_2 : smsr_pkg::LANES_1);

  always_comb begin
    unique case (lanes)
      smsr_pkg::LANES_4: rx_nxt = {rx_r[3:0], io_s2_r};
      smsr_pkg::LANES_2: rx_nxt = {rx_r[5:0], io_s2_r[1:0]};
      default: rx_nxt = {rx_r[6:0], io_s2_r[0]};
    endcase
  end

  assign byte_done = sck_rise && ((rx_cnt_r + lanes) == smsr_pkg::BITS_BYTE);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_r <= 8'h00;
      rx_cnt_r <= 4'h0;
    end else if (!sel) begin
      rx_cnt_r <= 4'h0;
    end else if (sck_rise) begin
      rx_r <= rx_nxt;
      rx_cnt_r <= byte_done ? 4'h0 : rx_cnt_r + lanes;
    end
  end

  // ==========================================
  // command sequencer
  logic opc_done, read_two_r;

  assign opc_done = byte_done && (state_r == smsr_pkg::SMSR_OPCODE);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= smsr_pkg::SMSR_OPCODE;
      read_two_r <= 1'b0;
    end else if (!sel) begin
      // chip deselect aborts any partial op-code
      state_r <= smsr_pkg::SMSR_OPCODE;
    end else if (opc_done) begin
      read_two_r <= (rx_nxt == smsr_pkg::OP_RD_STAT2);
      unique case (rx_nxt)
        smsr_pkg::OP_WR_STAT1: state_r <= smsr_pkg::SMSR_WRDATA;
        smsr_pkg::OP_RD_STAT1, smsr_pkg::OP_RD_STAT2: begin
          state_r <= smsr_pkg::SMSR_RDOUT;
        end
        default: state_r <= smsr_pkg::SMSR_IGNORE;
      endcase
    end else if (byte_done && state_r == smsr_pkg::SMSR_WRDATA) begin
      state_r <= smsr_pkg::SMSR_IGNORE;
    end
  end

  // io2 doubles as the protect pin outside quad mode only
  logic wp_low;
  assign wp_low = !quad_r && !io_s2_r[2];
  // latch must be set and the guard must not hold
  assign nv_wr = byte_done && state_r == smsr_pkg::SMSR_WRDATA &&
                 latch_r && !(nv_q[4] && wp_low);

  // ==========================================
  // volatile mode flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      quad_r <= smsr_pkg::VOL_RESET;
      dual_r <= smsr_pkg::VOL_RESET;
    end else if (opc_done) begin
      // status writes never reach these flags
      unique case (rx_nxt)
        smsr_pkg::OP_ENTER_QUAD: begin
          quad_r <= 1'b1;
          dual_r <= 1'b0;
        end
        smsr_pkg::OP_ENTER_DUAL: begin
          quad_r <= 1'b0;
          dual_r <= 1'b1;
        end
        smsr_pkg::OP_EXIT_MULTI: begin
          quad_r <= 1'b0;
          dual_r <= 1'b0;
        end
        default: begin
          quad_r <= quad_r;
          dual_r <= dual_r;
        end
      endcase
    end
  end

  // ==========================================
  // write enable latch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latch_r <= smsr_pkg::VOL_RESET;
    end else if (opc_done && rx_nxt == smsr_pkg::OP_SET_LATCH) begin
      latch_r <= 1'b1;
    end else if (opc_done && rx_nxt == smsr_pkg::OP_CLR_LATCH) begin
      latch_r <= 1'b0;
    end
    // no write command clears it, so writes may run back to back
  end

  // ==========================================
  // transmit path, launched on falling link edges
  function automatic logic [3:0] lane_slice(input logic [7:0] b,
                                            input logic [2:0] ph);
    logic [7:0] s;
    s = b << ph;
    lane_slice = s[7:4];
  endfunction

  logic [2:0] ph_r;
  logic drive_r;
  logic [3:0] out_r;
  logic [3:0] slice;
  logic [7:0] tx_byte;

  assign tx_byte = read_two_r ? stat2 : stat1;
  // status is live: each byte of a repeated read shows current state
  assign slice = lane_slice(tx_byte, ph_r);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph_r <= 3'h0;
      drive_r <= 1'b0;
      out_r <= 4'h0;
    end else if (!sel || state_r != smsr_pkg::SMSR_RDOUT) begin
      ph_r <= 3'h0;
      drive_r <= 1'b0;
    end else if (sck_fall) begin
      drive_r <= 1'b1;
      ph_r <= ph_r + lanes[2:0];
      unique case (lanes)
        smsr_pkg::LANES_4: out_r <= slice;
        smsr_pkg::LANES_2: out_r <= {2'b00, slice[3:2]};
        default: out_r <= {2'b00, slice[3], 1'b0};
      endcase
    end
  end

  assign io_out = out_r;
  always_comb begin
    io_oen = 4'hF;
    if (drive_r) begin
      unique case (lanes)
        smsr_pkg::LANES_4: io_oen = 4'h0;
        smsr_pkg::LANES_2: io_oen = 4'hC;
        default: io_oen = 4'hD;
      endcase
    end
  end

  assign quad_io_protocol_mode = quad_r;
  assign dual_io_protocol_mode = dual_r;
  assign write_enable_latch = latch_r;
  assign latency_sel = nv_q[3:2];
  assign block_protect = nv_q[1:0];
  assign status_write_guard_enable = nv_q[4];

endmodule

// ### tb/smsr_status1_properties.sv
`timescale 1ns/1ps
module smsr_props (
  // clock and resets
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic nv_erase_n,
  // link pins
  input wire logic link_sck,
  input wire logic link_cs_n,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oen,
  // state
  input wire logic quad_io_protocol_mode,
  input wire logic dual_io_protocol_mode,
  input wire logic write_enable_latch,
  input wire logic [1:0] latency_sel,
  input wire logic [1:0] block_protect,
  input wire logic status_write_guard_enable
);
  logic [4:0] nv;
  assign nv = {status_write_guard_enable, latency_sel, block_protect};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========================================
  // properties
  a_vol_clear: assert property ($rose(resetn) |->
    !quad_io_protocol_mode && !write_enable_latch) else $error("flags set");
  a_nv_kept: assert property ($rose(resetn) |-> $stable(nv))
    else $error("nv lost on reset");
  a_nv_gated: assert property ($changed(nv) |->
    $past(write_enable_latch) && write_enable_latch && !$past(link_cs_n))
    else $error("nv write not gated");
  a_guard_block: assert property ((status_write_guard_enable &&
    !quad_io_protocol_mode && !io_in[2]) [*4] |=> $stable(nv))
    else $error("guarded write went through");
  a_quad_frame: assert property ($changed(quad_io_protocol_mode) |->
    !$past(link_cs_n)) else $error("quad flag moved outside frame");
  a_latch_clear: assert property ($fell(write_enable_latch) |->
    !$past(link_cs_n)) else $error("latch fell outside frame");
  a_idle_release: assert property (link_cs_n [*8] |->
    io_oen == 4'hF) else $error("pins driven while deselected");
  a_single_lane: assert property (!quad_io_protocol_mode &&
    !dual_io_protocol_mode && io_oen != 4'hF |-> io_oen == 4'hD)
    else $error("wrong lanes in single mode");
  cover property ($rose(quad_io_protocol_mode));
  cover property ($rose(dual_io_protocol_mode));
  cover property ($changed(nv));
  cover property ($fell(write_enable_latch));
endmodule
bind smsr_status1 smsr_props u_props (.clk_sys(clk_sys), .resetn(resetn),
  .nv_erase_n(nv_erase_n), .link_sck(link_sck), .link_cs_n(link_cs_n),
  .io_in(io_in), .io_out(io_out), .io_oen(io_oen),
  .quad_io_protocol_mode(quad_io_protocol_mode),
  .dual_io_protocol_mode(dual_io_protocol_mode),
  .write_enable_latch(write_enable_latch), .latency_sel(latency_sel),
  .block_protect(block_protect),
  .status_write_guard_enable(status_write_guard_enable));

// ### tb/smsr_host.sv
`timescale 1ns/1ps
module smsr_host (
  // clock and device outputs
  input wire logic clk_sys,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oen,
  // link pins toward the device
  output logic link_sck,
  output logic link_cs_n,
  output logic [3:0] io_in
);
  // protect pin level, meaningful outside quad mode only
  logic wp_n = 1'b1;
  initial begin
    link_sck = 1'b0;
    link_cs_n = 1'b1;
    io_in = 4'hA;
  end
  // ==========================================
  // one mode 0 frame, ln lanes, msb first, 125 ns link clock
  task automatic xfer(input int ln, input logic [7:0] op,
    input logic [7:0] wd, input int nb, output logic [7:0] rd);
    logic [15:0] tx;
    int k;
    tx = {op, wd};
    rd = 8'h00;
    @(posedge clk_sys);
    // offset keeps link edges off the system clock edges
    #2 link_cs_n = 1'b0;
    for (int i = 0; i < nb * 8; i += ln) begin
      // idle lanes 0-1 toggle so a stale level is never trusted; below four lanes io2 holds wp_n, io3 stays high
      io_in = {1'b1, wp_n, ~io_in[1:0]};
      for (int j = 0; j < ln; j++) io_in[j] = tx[16 - i - ln + j];
      #62.5 link_sck = 1'b1;
      if (i >= 8) begin
        for (int j = ln - 1; j >= 0; j--) begin
          k = (ln == 1) ? 1 : j;
          // an undriven lane reads inverted, so a late enable shows up
          rd = {rd[6:0], io_oen[k] ? ~io_out[k] : io_out[k]};
        end
      end
      #62.5 link_sck = 1'b0;
    end
    #62.5 link_cs_n = 1'b1;
    io_in = {1'b1, wp_n, ~io_in[1:0]};
    #60;
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic nv_erase_n = 1'b0;
  logic link_sck, link_cs_n, quad, dual, wr_latch, guard;
  logic [3:0] io_in, io_out, io_oen;
  logic [1:0] lat, bp;
  logic [7:0] rd;
  int err_total = 0;
  int n_tests = 0;
  always #5 clk_sys = ~clk_sys;
  smsr_host host (.clk_sys(clk_sys), .io_out(io_out), .io_oen(io_oen),
    .link_sck(link_sck), .link_cs_n(link_cs_n), .io_in(io_in));
  smsr_status1 uut (.clk_sys(clk_sys), .resetn(resetn),
    .nv_erase_n(nv_erase_n), .link_sck(link_sck), .link_cs_n(link_cs_n),
    .io_in(io_in), .io_out(io_out), .io_oen(io_oen),
    .quad_io_protocol_mode(quad), .dual_io_protocol_mode(dual),
    .write_enable_latch(wr_latch), .latency_sel(lat), .block_protect(bp),
    .status_write_guard_enable(guard));
  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rds(input int ln, input logic [7:0] op);
    host.xfer(ln, op, 8'h5A, 2, rd);
  endtask
  task automatic cmd(input int ln, input logic [7:0] op, input logic [7:0] wd);
    host.xfer(ln, op, wd, op == smsr_pkg::OP_WR_STAT1 ? 2 : 1, rd);
  endtask
  // ==========================================
  // scenarios
  task automatic t_latch;
    rds(1, smsr_pkg::OP_RD_STAT1);
    chk("power-on status", 8'h00, rd);
    cmd(1, smsr_pkg::OP_SET_LATCH, 8'h00);
    rds(1, smsr_pkg::OP_RD_STAT1);
    chk("latch set", 8'h02, rd);
    cmd(1, smsr_pkg::OP_CLR_LATCH, 8'h00);
    chk("latch port", 8'h00, {7'h00, wr_latch});
    $display("t_latch done");
  endtask
  task automatic t_write;
    cmd(1, smsr_pkg::OP_WR_STAT1, 8'hFF);
    rds(1, smsr_pkg::OP_RD_STAT1);
    chk("write without latch", 8'h00, rd);
    cmd(1, smsr_pkg::OP_SET_LATCH, 8'h00);
    cmd(1, smsr_pkg::OP_WR_STAT1, 8'hFF);
    rds(1, smsr_pkg::OP_RD_STAT1);
    chk("write all ones", 8'hBE, rd);
    host.wp_n = 1'b0;
    cmd(1, smsr_pkg::OP_WR_STAT1, 8'h00);
    rds(1, smsr_pkg::OP_RD_STAT1);
    chk("guarded write", 8'hBE, rd);
    host.wp_n = 1'b1;
    cmd(1, smsr_pkg::OP_WR_STAT1, 8'h24);
    rds(1, smsr_pkg::OP_RD_STAT1);
    chk("field write", 8'h26, rd);
    chk("field ports", 8'h09, {3'h0, guard, lat, bp});
    $display("t_write done");
  endtask
  task automatic t_quad;
    cmd(1, smsr_pkg::OP_ENTER_QUAD, 8'h00);
    rds(4, smsr_pkg::OP_RD_STAT1);
    chk("quad status1", 8'h66, rd);
    rds(4, smsr_pkg::OP_RD_STAT2);
    chk("quad status2", 8'h40, rd);
    cmd(4, smsr_pkg::OP_ENTER_DUAL, 8'h00);
    chk("dual clears quad", 8'h01, {6'h00, quad, dual});
    rds(2, smsr_pkg::OP_RD_STAT2);
    chk("dual status2", 8'h20, rd);
    cmd(2, smsr_pkg::OP_EXIT_MULTI, 8'h00);
    cmd(1, smsr_pkg::OP_ENTER_QUAD, 8'h00);
    cmd(4, smsr_pkg::OP_EXIT_MULTI, 8'h00);
    chk("exit clears quad", 8'h00, {6'h00, quad, dual});
    $display("t_quad done");
  endtask
  task automatic t_rst2;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rds(1, smsr_pkg::OP_RD_STAT1);
    chk("status after reset", 8'h24, rd);
    rds(1, smsr_pkg::OP_RD_STAT2);
    chk("status2 after reset", 8'h00, rd);
    $display("t_rst2 done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    nv_erase_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_latch;
    t_write;
    t_quad;
    t_rst2;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    final_report;
  end
endmodule
